//--- rtl/rspc_defs.svh
// Offsets, field positions, reset values and timing counts of the reset block.
`ifndef RSPC_DEFS_SVH
`define RSPC_DEFS_SVH

// Register indices; the byte address is four times the index.
`define RSPC_IDX_MODE 10'h0EB
`define RSPC_IDX_RCTL 10'h0F0
`define RSPC_IDX_CAUSE 10'h0F1
`define RSPC_IDX_ISTAT 10'h0F2
`define RSPC_IDX_IMASK 10'h0F3

`define RSPC_MODE_RESET 8'hE0
`define RSPC_MODE_FIXED 8'hC0
`define RSPC_MODE_WMASK 8'h3C
`define RSPC_BIT_HALF 5
`define RSPC_PRS_HI 4
`define RSPC_PRS_LO 2

`define RSPC_BIT_HRE 7
`define RSPC_BIT_PREL 0
`define RSPC_BIT_SOFT 5
`define RSPC_BIT_WDG 6

`define RSPC_IRQ_PIN 0
`define RSPC_IRQ_SOFT 1
`define RSPC_IRQ_WDG 2
`define RSPC_IRQ_HALT 3
`define RSPC_IRQ_W 4

`define RSPC_STRETCH_PERIODS 32768
`define RSPC_GAP_PERIODS 511

`endif

//--- rtl/rspc_pkg.sv
// Types shared by the reset and clock prescale block.
package rspc_pkg;

    typedef enum logic [4:0] {
        RSPC_RUN = 5'h01,
        RSPC_HOLD = 5'h02,
        RSPC_STRETCH = 5'h04,
        RSPC_GAP = 5'h08,
        RSPC_HALT = 5'h10
    } rspc_state_t;

    typedef struct packed {
        logic internal_clock;
        logic cpu_core_clock;
    } rspc_clk_t;

    typedef struct packed {
        logic osc_enable;
        logic osc_output_oe;
        logic clock_held_high;
    } rspc_osc_t;

endpackage

//--- rtl/rspc_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module rspc_sync (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic async_in, // Pin level from outside the clock domain.
    output logic level // Filtered level.
);
    logic ff1;
    logic ff2;
    logic ff3;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ff1 <= 1'b0;
            ff2 <= 1'b0;
            ff3 <= 1'b0;
        end else begin
            ff1 <= async_in;
            ff2 <= ff1;
            ff3 <= ff2;
        end
    end

    // Starting low makes power-up look like a pin reset until the pin is seen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
        end else if (ff2 == ff3) begin
            level <= ff3;
        end
    end
endmodule

//--- rtl/rspc_top.sv
// Reset/stop manager and core clock prescaler with an APB register port.
// Operation
// - Pin low, enabled halt, watchdog cause reset.
// - Held reset lasts 32768 periods after pin.
// - Held reset driven low on port pin.
// - Core reset released 511 periods later.
// - Last reset cause readable, bits 5, 6.
// - Halt without watchdog or halt reset stops oscillator, clock high.
// - Only a pin reset leaves oscillator halt.
// - Watchdog enabled: halt keeps oscillator running.
// - Clock edges ignored while oscillator halted.
// - Mode bit 5 halves oscillator clock.
// - Prescale field divides CPU clock by value+1.
// - Prescale zero gives undivided CPU clock.
// - Mode register resets to E0h.
// - Halt resets if enabled, else PLL off.
// - Watchdog reset flag set, read only.
`timescale 1ns/1ps
`include "rspc_defs.svh"
module rspc_top
    import rspc_pkg::*;
#(
    parameter int STRETCH_CYCLES = `RSPC_STRETCH_PERIODS
) (
    input wire logic pclk, // Oscillator input clock, 250 MHz.
    input wire logic presetn, // Power-on reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic ext_reset_pin_n, // External reset pin, active low.
    input wire logic halt_req, // Halt instruction, one-cycle pulse.
    input wire logic watchdog_enable, // Watchdog running.
    input wire logic watchdog_eoc, // Watchdog end of count pulse.
    output logic held_reset_out, // Held reset value on the port pin.
    output logic held_reset_oe, // Port pin output enable.
    output logic core_reset_n, // Reset to all macrocells, active low.
    output logic pll_off, // Pulse that turns off PLL and slow-down.
    output rspc_clk_t clk_en, // Internal and CPU clock enables.
    output rspc_osc_t osc, // Oscillator control.
    output logic irq // Interrupt, high while unmasked status set.
);
    // Each timed phase ends when the counter holds its last value, so a
    // phase lasts exactly its number of clock periods.
    localparam logic [15:0] STRETCH_LAST = 16'(STRETCH_CYCLES - 1);
    localparam logic [15:0] GAP_LAST = 16'(`RSPC_GAP_PERIODS - 1);

    function automatic logic idx_hit(input logic [11:0] a,
                                     input logic [9:0] idx);
        idx_hit = (a[1:0] == 2'h0) && (a[11:2] == idx);
    endfunction

    rspc_state_t state;
    rspc_state_t next_state;
    logic pin_level;
    logic [15:0] cnt;
    logic [7:0] mode;
    logic halt_reset_enable;
    logic port_release;
    logic [1:0] cause;
    logic [`RSPC_IRQ_W-1:0] istat;
    logic [`RSPC_IRQ_W-1:0] imask;
    logic half_toggle;
    logic [2:0] prs_cnt;
    logic [2:0] prs;
    logic next_int;
    logic evt_pin;
    logic evt_soft;
    logic evt_wdg;
    logic evt_halt;
    logic trigger;
    logic setup;
    logic wr;
    logic mapped;
    logic [31:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Reset pin is brought into the clock domain before anything uses it.
    rspc_sync u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(ext_reset_pin_n),
        .level(pin_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencing.
    always_comb begin
        next_state = state;
        case (state)
            RSPC_RUN: begin
                // The pin outranks every other cause; a plain halt is last.
                if (!pin_level) begin
                    next_state = RSPC_HOLD;
                end else if (halt_req && halt_reset_enable) begin
                    next_state = RSPC_STRETCH;
                end else if (watchdog_eoc) begin
                    next_state = RSPC_STRETCH;
                end else if (halt_req && !watchdog_enable) begin
                    next_state = RSPC_HALT;
                end
            end
            RSPC_HOLD: begin
                if (pin_level) begin
                    next_state = RSPC_STRETCH;
                end
            end
            RSPC_STRETCH: begin
                if (!pin_level) begin
                    next_state = RSPC_HOLD;
                end else if (cnt == STRETCH_LAST) begin
                    next_state = RSPC_GAP;
                end
            end
            RSPC_GAP: begin
                if (!pin_level) begin
                    next_state = RSPC_HOLD;
                end else if (cnt == GAP_LAST) begin
                    next_state = RSPC_RUN;
                end
            end
            RSPC_HALT: begin
                // Nothing but the pin can wake a stopped oscillator.
                if (!pin_level) begin
                    next_state = RSPC_HOLD;
                end
            end
            default: begin
                next_state = RSPC_HOLD;
            end
        endcase
    end

    assign evt_pin = (next_state == RSPC_HOLD) && (state != RSPC_HOLD);
    assign evt_soft = (state == RSPC_RUN) && pin_level && halt_req &&
                      halt_reset_enable;
    assign evt_wdg = (state == RSPC_RUN) && pin_level && !evt_soft &&
                     watchdog_eoc;
    assign evt_halt = (state == RSPC_RUN) && pin_level && halt_req &&
                      !halt_reset_enable && !watchdog_eoc;
    assign trigger = evt_pin || evt_soft || evt_wdg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= RSPC_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // One counter times both phases; it restarts on every change of state,
    // so a pin pulse in mid-phase starts the whole sequence again.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 16'h0000;
        end else if (next_state != state) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

    // Outputs are decoded from the next state, pll_off from evt_halt, so they move on the same edge
    // as the state itself, one cycle after the decision.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_reset_out <= 1'b0;
            core_reset_n <= 1'b0;
            pll_off <= 1'b0;
        end else begin
            held_reset_out <= !(next_state == RSPC_HOLD ||
                                next_state == RSPC_STRETCH);
            core_reset_n <= (next_state == RSPC_RUN ||
                             next_state == RSPC_HALT);
            pll_off <= evt_halt;
        end
    end

    // The pin stays driven until software hands the port bit back.
    assign held_reset_oe = !port_release;

    ////////////////////////////////////////////////////////////////////////
    // Oscillator and clock enables.
    assign prs = mode[`RSPC_PRS_HI:`RSPC_PRS_LO];
    assign next_int = !mode[`RSPC_BIT_HALF] || half_toggle;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc <= '{osc_enable: 1'b1, osc_output_oe: 1'b1,
                     clock_held_high: 1'b0};
        end else begin
            osc.osc_enable <= (next_state != RSPC_HALT);
            osc.osc_output_oe <= (next_state != RSPC_HALT);
            osc.clock_held_high <= (next_state == RSPC_HALT);
        end
    end

    // Gating the enables in halt also drops any stray oscillator edges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_toggle <= 1'b0;
            prs_cnt <= 3'h0;
            clk_en <= '0;
        end else if (next_state == RSPC_HALT) begin
            half_toggle <= 1'b0;
            prs_cnt <= 3'h0;
            clk_en <= '0;
        end else begin
            half_toggle <= !half_toggle;
            clk_en.internal_clock <= next_int;
            clk_en.cpu_core_clock <= next_int && (prs_cnt >= prs);
            if (next_int) begin
                // Prescale zero wraps every internal tick, so no division.
                if (prs_cnt >= prs) begin
                    prs_cnt <= 3'h0;
                end else begin
                    prs_cnt <= prs_cnt + 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup cycle.
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        mapped = 1'b1;
        next_rdata = 32'h00000000;
        if (idx_hit(paddr, `RSPC_IDX_MODE)) begin
            next_rdata[7:0] = mode;
        end else if (idx_hit(paddr, `RSPC_IDX_RCTL)) begin
            next_rdata[`RSPC_BIT_HRE] = halt_reset_enable;
            next_rdata[`RSPC_BIT_PREL] = port_release;
        end else if (idx_hit(paddr, `RSPC_IDX_CAUSE)) begin
            next_rdata[`RSPC_BIT_SOFT] = cause[0];
            next_rdata[`RSPC_BIT_WDG] = cause[1];
        end else if (idx_hit(paddr, `RSPC_IDX_ISTAT)) begin
            next_rdata[`RSPC_IRQ_W-1:0] = istat;
        end else if (idx_hit(paddr, `RSPC_IDX_IMASK)) begin
            next_rdata[`RSPC_IRQ_W-1:0] = imask;
        end else begin
            mapped = 1'b0;
        end
    end

    // Loading in the setup cycle lets the data stand through the access
    // phase with no wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers; a reset trigger returns mode and reset control to defaults and loads the cause.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= `RSPC_MODE_RESET;
        end else if (trigger) begin
            mode <= `RSPC_MODE_RESET;
        end else if (wr && idx_hit(paddr, `RSPC_IDX_MODE)) begin
            mode <= `RSPC_MODE_FIXED | (pwdata[7:0] & `RSPC_MODE_WMASK);
        end
    end

    // A trigger in the same cycle as a write wins, so software cannot keep
    // halt reset armed or the port bit released across a reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_reset_enable <= 1'b0;
            port_release <= 1'b0;
        end else if (trigger) begin
            halt_reset_enable <= 1'b0;
            port_release <= 1'b0;
        end else if (wr && idx_hit(paddr, `RSPC_IDX_RCTL)) begin
            halt_reset_enable <= pwdata[`RSPC_BIT_HRE];
            port_release <= pwdata[`RSPC_BIT_PREL];
        end
    end

    // Cause is written by hardware only; bus writes are ignored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause <= 2'h0;
        end else if (evt_pin) begin
            cause <= 2'h0;
        end else if (evt_soft) begin
            cause <= 2'h1;
        end else if (evt_wdg) begin
            cause <= 2'h2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: hardware set wins over a write-one clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat <= '0;
        end else begin
            for (int i = 0; i < `RSPC_IRQ_W; i++) begin
                if (wr && idx_hit(paddr, `RSPC_IDX_ISTAT) && pwdata[i]) begin
                    istat[i] <= 1'b0;
                end
            end
            if (evt_pin) begin
                istat[`RSPC_IRQ_PIN] <= 1'b1;
            end
            if (evt_soft) begin
                istat[`RSPC_IRQ_SOFT] <= 1'b1;
            end
            if (evt_wdg) begin
                istat[`RSPC_IRQ_WDG] <= 1'b1;
            end
            if (evt_halt) begin
                istat[`RSPC_IRQ_HALT] <= 1'b1;
            end
        end
    end

    // Masking only hides an event from the interrupt; the status bit stays.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask <= '0;
        end else if (wr && idx_hit(paddr, `RSPC_IDX_IMASK)) begin
            imask <= pwdata[`RSPC_IRQ_W-1:0];
        end
    end

    // A level output: it falls as soon as software clears or masks the bit.
    assign irq = |(istat & imask);
endmodule

//--- testbench/rspc_top_assertions.sv
// Concurrent checks on the ports of the reset and clock prescale block.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module rspc_top_chk
    import rspc_pkg::*;
#(
    parameter int STRETCH_CYCLES = 32768
) (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pslverr, // APB error.
    input wire logic ext_reset_pin_n, // Reset pin.
    input wire logic halt_req, // Halt pulse.
    input wire logic watchdog_enable, // Watchdog running.
    input wire logic watchdog_eoc, // Watchdog end of count.
    input wire logic held_reset_out, // Held reset.
    input wire logic core_reset_n, // Core reset.
    input wire logic pll_off, // PLL off pulse.
    input wire rspc_clk_t clk_en, // Clock enables.
    input wire rspc_osc_t osc // Oscillator control.
);
    logic [15:0] low_cnt;
    logic [9:0] gap_cnt;
    logic [2:0] hi_cnt;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Lengths of the held phase, the gap, and how long the pin stayed high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= '0;
            gap_cnt <= '0;
            hi_cnt <= '0;
        end else begin
            low_cnt <= held_reset_out ? 16'h0000 : low_cnt + 16'h0001;
            if (!held_reset_out) begin
                gap_cnt <= '0;
            end else if (!core_reset_n) begin
                gap_cnt <= gap_cnt + 10'h001;
            end
            if (!ext_reset_pin_n) begin
                hi_cnt <= '0;
            end else if (hi_cnt != 3'h7) begin
                hi_cnt <= hi_cnt + 3'h1;
            end
        end
    end

    hold_core_a: assert property (
        !held_reset_out |-> !core_reset_n)
        else $error("core reset released while held reset active");
    stretch_len_a: assert property (
        $rose(held_reset_out) |-> low_cnt >= STRETCH_CYCLES)
        else $error("held reset released too early");
    gap_len_a: assert property (
        $rose(core_reset_n) |-> gap_cnt == 10'h1FF)
        else $error("gap before core reset release is wrong");
    pin_reset_a: assert property (
        (!ext_reset_pin_n) [*7] |-> !held_reset_out && !core_reset_n)
        else $error("pin low did not reset the device");
    halt_stop_a: assert property (
        osc.clock_held_high |-> !osc.osc_enable && !osc.osc_output_oe &&
        !clk_en.internal_clock && !clk_en.cpu_core_clock)
        else $error("halted clock not fully stopped");
    halt_hold_a: assert property (
        !osc.osc_enable && hi_cnt == 3'h7 |=> !osc.osc_enable)
        else $error("oscillator restarted without a pin reset");
    wdg_halt_a: assert property (
        halt_req && watchdog_enable && osc.osc_enable |=> osc.osc_enable)
        else $error("halt stopped oscillator with watchdog on");
    wdg_reset_a: assert property (
        watchdog_eoc && core_reset_n && osc.osc_enable |-> ##[1:2]
        !held_reset_out)
        else $error("watchdog end of count did not reset");
    pll_pulse_a: assert property (
        pll_off |-> $past(halt_req) ##1 !pll_off)
        else $error("pll off pulse malformed");
    apb_err_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");

    cover property ($rose(pll_off));
    cover property ($rose(core_reset_n));
    cover property (osc.clock_held_high);
endmodule

bind rspc_top rspc_top_chk #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_chk (
    .pclk, .presetn, .psel, .penable, .pslverr, .ext_reset_pin_n,
    .halt_req, .watchdog_enable, .watchdog_eoc, .held_reset_out,
    .core_reset_n, .pll_off, .clk_en, .osc
);

//--- testbench/rspc_top_bench.sv
// Self-checking bench for the reset and clock prescale block.
`timescale 1ns/1ps
`include "rspc_defs.svh"
////////////////////////////////////////////////////////////////////////////
module rspc_top_bench;
    import rspc_pkg::*;
    localparam int STRETCH = 16;
    localparam logic [9:0] a_mode = `RSPC_IDX_MODE;
    localparam logic [9:0] a_ctrl = `RSPC_IDX_RCTL;
    localparam logic [9:0] a_cause = `RSPC_IDX_CAUSE;
    localparam logic [9:0] a_stat = `RSPC_IDX_ISTAT;
    localparam logic [9:0] a_mask = `RSPC_IDX_IMASK;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic ext_reset_pin_n = 1, halt_req = 0, watchdog_enable = 0;
    logic watchdog_eoc = 0, pready, pslverr, held_reset_out, er, pl;
    logic held_reset_oe, core_reset_n, pll_off, irq;
    rspc_clk_t clk_en;
    rspc_osc_t osc;
    int n_mismatch = 0, tests_run = 0, cyc = 0;

    rspc_top #(.STRETCH_CYCLES(STRETCH)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_reset_pin_n, .halt_req,
        .watchdog_enable, .watchdog_eoc, .held_reset_out, .held_reset_oe,
        .core_reset_n, .pll_off, .clk_en, .osc, .irq
    );

    always #2 pclk = ~pclk;

    task end_sim;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            n_mismatch++;
            end_sim;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The answer is read right after the edge that sees pready, which gives
    // the values that edge sampled; the bus then idles to the falling edge.
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    // A one-cycle pulse; pll_off one cycle after it is kept in pl.
    task trig(input int k);
        @(posedge pclk);
        if (k == 0) begin
            halt_req <= 1'b1;
        end else begin
            watchdog_eoc <= 1'b1;
        end
        @(posedge pclk);
        halt_req <= 1'b0;
        watchdog_eoc <= 1'b0;
        @(negedge pclk);
        pl = pll_off;
        @(negedge pclk);
    endtask

    task wait_core(input logic v);
        int n;
        n = 0;
        while (core_reset_n !== v && n < 3000) begin
            @(negedge pclk);
            n++;
        end
        chk(core_reset_n, v);
    endtask

    task t_regs;
        apb(0, a_mode, 0);
        chk(rd, 32'hE0);
        apb(1, a_mode, 32'hFFFFFFFF);
        apb(0, a_mode, 0);
        chk(rd, 32'hFC);
        apb(0, 10'h3FF, 0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        wait_core(1);
        chk(held_reset_out, 1'b1);
        chk(held_reset_oe, 1'b1);
        apb(1, a_ctrl, 32'h1);
        chk(held_reset_oe, 1'b0);
    endtask

    // A window of 1680 cycles holds a whole number of every divided period.
    task t_prescale;
        int ni, nc;
        for (int h = 0; h < 2; h++) begin
            for (int p = 0; p < 8; p++) begin
                apb(1, a_mode, 32'(h * 32 + p * 4));
                repeat (20) @(posedge pclk);
                ni = 0;
                nc = 0;
                repeat (1680) begin
                    @(negedge pclk);
                    ni += (clk_en.internal_clock === 1'b1) ? 1 : 0;
                    nc += (clk_en.cpu_core_clock === 1'b1) ? 1 : 0;
                end
                chk(ni, 1680 / (h + 1));
                chk(nc, 1680 / ((h + 1) * (p + 1)));
            end
        end
    endtask

    task t_soft;
        apb(1, a_mask, 32'hF);
        apb(1, a_stat, 32'hF);
        apb(1, a_ctrl, 32'h80);
        chk(irq, 1'b0);
        trig(0);
        chk({held_reset_out, core_reset_n}, 2'b00);
        chk(pl, 1'b0);
        chk(held_reset_oe, 1'b1);
        chk(irq, 1'b1);
        wait_core(1);
        apb(0, a_cause, 0);
        chk(rd, 32'h20);
        apb(0, a_mode, 0);
        chk(rd, 32'hE0);
        apb(0, a_stat, 0);
        chk(rd, 32'h2);
        apb(1, a_mask, 32'hD);
        chk(irq, 1'b0);
        apb(1, a_mask, 32'hF);
        chk(irq, 1'b1);
        apb(1, a_stat, 32'h2);
        chk(irq, 1'b0);
    endtask

    task t_wdg;
        trig(1);
        chk(held_reset_out, 1'b0);
        wait_core(1);
        apb(1, a_cause, 0);
        apb(0, a_cause, 0);
        chk(rd, 32'h40);
        apb(0, a_stat, 0);
        chk(rd, 32'h4);
        apb(1, a_stat, 32'h4);
    endtask

    task t_halt;
        @(posedge pclk);
        watchdog_enable <= 1'b1;
        trig(0);
        chk(pl, 1'b1);
        chk({osc.osc_enable, core_reset_n}, 2'b11);
        apb(0, a_stat, 0);
        chk(rd, 32'h8);
        apb(1, a_stat, 32'h8);
        @(posedge pclk);
        watchdog_enable <= 1'b0;
        // No other analog part is modelled, so nothing else is stopped first.
        trig(0);
        chk(pl, 1'b1);
        chk(osc, 3'b001);
        chk(clk_en, 2'b00);
        repeat (30) @(negedge pclk);
        chk(osc, 3'b001);
        chk(clk_en, 2'b00);
        @(posedge pclk);
        ext_reset_pin_n <= 1'b0;
        repeat (10) @(posedge pclk);
        ext_reset_pin_n <= 1'b1;
        repeat (STRETCH) @(negedge pclk);
        chk(held_reset_out, 1'b0);
        wait_core(1);
        chk(osc, 3'b110);
        apb(0, a_cause, 0);
        chk(rd, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_prescale;
        t_soft;
        t_wdg;
        t_halt;
        end_sim;
    end
endmodule
